// *** cec_cfg.svh ***
// Register map, field positions, reset values, edge mode codes and event bits.
`ifndef CEC_CFG_SVH
`define CEC_CFG_SVH
`define CEC_ADDR_W          4
`define CEC_OFF_CTRL        4'h0
`define CEC_OFF_PIN_DIGITAL_INPUT_DISABLE        4'h4
`define CEC_OFF_STATUS      4'h8
`define CEC_OFF_MASK        4'hc
`define CEC_BIT_POWER_OFF   7
`define CEC_BIT_REF_SEL     6
`define CEC_BIT_RESULT      5
`define CEC_BIT_FLAG        4
`define CEC_BIT_IRQ_EN      3
`define CEC_BIT_CAPTURE     2
`define CEC_BIT_POS_OFF     0
`define CEC_BIT_NEG_OFF     1
`define CEC_CTRL_RESET      8'h00
`define CEC_PIN_DIGITAL_INPUT_DISABLE_RESET      8'h00
`define CEC_MODE_TOGGLE     2'h0
`define CEC_MODE_FALL       2'h2
`define CEC_MODE_RISE       2'h3
`define CEC_EV_BIT_EDGE     0
`define CEC_EV_BIT_RISE     1
`define CEC_EV_BIT_FALL     2
`endif

// *** cec_cmp_model.sv ***
// Behavioural comparator core and timer capture unit.
`timescale 1ns/100ps
module cec_cmp_model #(
  parameter int BANDGAP_MV = 1100
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Analog levels in millivolts.
  input  wire logic [15:0] pos_mv,
  input  wire logic [15:0] neg_mv,
  // Control from the block, and the capture interrupt enable from the bench.
  input  wire logic        power_off,
  input  wire logic        ref_sel,
  input  wire logic        capture_source,
  input  wire logic        capture_irq_enable,
  // Results.
  output logic             raw_out,
  output logic [7:0]       capture_count,
  output logic             capture_irq
);
  logic last_src;
  // A powered comparator picks bandgap or pin as its positive input.
  assign raw_out = !power_off &&
    ((ref_sel ? 16'(BANDGAP_MV) : pos_mv) > neg_mv);
  // The capture unit counts rising edges of its source.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      last_src      <= 1'b0;
      capture_count <= 8'h00;
      capture_irq   <= 1'b0;
    end else begin
      last_src <= capture_source;
      if (capture_source && !last_src) begin
        capture_count <= capture_count + 8'h01;
        capture_irq   <= capture_irq | capture_irq_enable;
      end
    end
  end
endmodule

// *** cec_pkg.sv ***
// Types shared by the comparator event control block.
package cec_pkg;
  typedef logic [1:0] cec_mode_t;
  typedef logic [7:0] cec_byte_t;
  typedef enum logic [1:0] {
    CEC_IDLE,
    CEC_DONE
  } cec_bus_e;
endpackage

// *** cec_sync2.sv ***
// Two-stage synchroniser for one level.
`timescale 1ns/100ps
module cec_sync2 (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic resetn,
  // Level in and out.
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** cec_top.sv ***
// Comparator control, edge event and interrupt logic with Avalon-MM slave.
`timescale 1ns/100ps
`include "cec_cfg.svh"
module cec_top (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  // Avalon-MM slave.
  input  wire logic [`CEC_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  output logic      [1:0]             avs_response,
  // Comparator core.
  input  wire logic                   comp_raw_out,
  output logic                        comparator_power_off,
  output logic                        reference_select,
  // Pins and port read path.
  input  wire logic                   positive_input_pin_digital,
  input  wire logic                   negative_input_pin_digital,
  output logic                        positive_pin_buffer_off,
  output logic                        negative_pin_buffer_off,
  output logic                        positive_port_in,
  output logic                        negative_port_in,
  // Timer capture front end.
  output logic                        capture_route_enable,
  output logic                        capture_source,
  // CPU interrupt.
  input  wire logic                   global_irq_enable,
  input  wire logic                   vector_ack,
  output logic                        compare_irq_req,
  output logic                        irq
);

  // ----------------------------------------------------------------------
  // Functions.
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [`CEC_ADDR_W-1:0] a,
                               input logic [`CEC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mode_match(input cec_pkg::cec_mode_t m,
                                      input logic rise,
                                      input logic fall);
    unique case (m)
      `CEC_MODE_TOGGLE: mode_match = rise | fall;
      `CEC_MODE_FALL:   mode_match = fall;
      `CEC_MODE_RISE:   mode_match = rise;
      default:          mode_match = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Registers and state.
  // ----------------------------------------------------------------------
  logic                 compare_irq_enable;
  cec_pkg::cec_mode_t   edge_mode;
  logic                 compare_event_flag;
  logic                 compare_result;
  logic                 result_prev;
  logic [2:0]           ev_status;
  logic [2:0]           ev_mask;
  cec_pkg::cec_bus_e    bus_state;
  logic                 pos_sync;
  logic                 neg_sync;
  logic                 wr_hit;
  logic                 rd_hit;
  logic                 rise;
  logic                 fall;
  logic                 match;
  logic [2:0]           ev_now;
  logic                 wr_ctrl;
  logic                 wr_pin_digital_input_disable;
  logic                 rd_status;
  cec_pkg::cec_byte_t   next_rdata;

  // ----------------------------------------------------------------------
  // Comparator result and pin synchronisation, edge detect.
  // ----------------------------------------------------------------------
  cec_sync2 u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (comp_raw_out),
    .sync_out (compare_result)
  );

  cec_sync2 u_pos_pin (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (positive_input_pin_digital),
    .sync_out (pos_sync)
  );

  cec_sync2 u_neg_pin (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (negative_input_pin_digital),
    .sync_out (neg_sync)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_prev <= 1'b0;
    end else begin
      result_prev <= compare_result;
    end
  end

  assign rise  = compare_result & ~result_prev;
  assign fall  = ~compare_result & result_prev;
  assign match = mode_match(edge_mode, rise, fall);
  assign ev_now = {fall, rise, match};

  // ----------------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------------
  assign wr_hit    = avs_write && bus_state == cec_pkg::CEC_IDLE;
  assign rd_hit    = avs_read && bus_state == cec_pkg::CEC_IDLE;
  assign wr_ctrl   = wr_hit && hit(avs_address, `CEC_OFF_CTRL)
                     && avs_byteenable[0];
  assign wr_pin_digital_input_disable   = wr_hit && hit(avs_address, `CEC_OFF_PIN_DIGITAL_INPUT_DISABLE)
                     && avs_byteenable[0];
  assign rd_status = rd_hit && hit(avs_address, `CEC_OFF_STATUS);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state <= cec_pkg::CEC_IDLE;
    end else begin
      unique case (bus_state)
        cec_pkg::CEC_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= cec_pkg::CEC_DONE;
          end
        end
        cec_pkg::CEC_DONE: begin
          bus_state <= cec_pkg::CEC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write)
                           && bus_state == cec_pkg::CEC_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Control register fields.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      comparator_power_off <= 1'b0;
      reference_select     <= 1'b0;
      compare_irq_enable   <= 1'b0;
      capture_route_enable <= 1'b0;
      edge_mode            <= 2'h0;
    end else if (wr_ctrl) begin
      comparator_power_off <= avs_writedata[`CEC_BIT_POWER_OFF];
      reference_select     <= avs_writedata[`CEC_BIT_REF_SEL];
      compare_irq_enable   <= avs_writedata[`CEC_BIT_IRQ_EN];
      capture_route_enable <= avs_writedata[`CEC_BIT_CAPTURE];
      edge_mode            <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      positive_pin_buffer_off <= 1'b0;
      negative_pin_buffer_off <= 1'b0;
    end else if (wr_pin_digital_input_disable) begin
      positive_pin_buffer_off <= avs_writedata[`CEC_BIT_POS_OFF];
      negative_pin_buffer_off <= avs_writedata[`CEC_BIT_NEG_OFF];
    end
  end

  // ----------------------------------------------------------------------
  // Event flag and comparator interrupt request.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      compare_event_flag <= 1'b0;
    end else if (match) begin
      compare_event_flag <= 1'b1;
    end else if (vector_ack ||
                 (wr_ctrl && avs_writedata[`CEC_BIT_FLAG])) begin
      compare_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      compare_irq_req <= 1'b0;
    end else begin
      compare_irq_req <= compare_event_flag & compare_irq_enable
                         & global_irq_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Capture route and port read path.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      capture_source   <= 1'b0;
      positive_port_in <= 1'b0;
      negative_port_in <= 1'b0;
    end else begin
      capture_source   <= capture_route_enable & compare_result;
      positive_port_in <= pos_sync & ~positive_pin_buffer_off;
      negative_port_in <= neg_sync & ~negative_pin_buffer_off;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky status, mask and interrupt line.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ev_status <= 3'h0;
    end else begin
      ev_status <= (rd_status ? 3'h0 : ev_status) | ev_now;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ev_mask <= 3'h0;
    end else if (wr_hit && hit(avs_address, `CEC_OFF_MASK)
                 && avs_byteenable[0]) begin
      ev_mask <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_status & ev_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (hit(avs_address, `CEC_OFF_CTRL)) begin
      next_rdata = {comparator_power_off, reference_select, compare_result,
                    compare_event_flag, compare_irq_enable,
                    capture_route_enable, edge_mode};
    end else if (hit(avs_address, `CEC_OFF_PIN_DIGITAL_INPUT_DISABLE)) begin
      next_rdata = {6'h00, negative_pin_buffer_off, positive_pin_buffer_off};
    end else if (hit(avs_address, `CEC_OFF_STATUS)) begin
      next_rdata = {5'h00, ev_status};
    end else if (hit(avs_address, `CEC_OFF_MASK)) begin
      next_rdata = {5'h00, ev_mask};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else if (rd_hit || wr_hit) begin
      avs_readdata <= rd_hit ? {24'h00_0000, next_rdata} : 32'h0000_0000;
      avs_response <= (hit(avs_address, `CEC_OFF_CTRL)
                       || hit(avs_address, `CEC_OFF_PIN_DIGITAL_INPUT_DISABLE)
                       || hit(avs_address, `CEC_OFF_STATUS)
                       || hit(avs_address, `CEC_OFF_MASK)) ? 2'h0 : 2'h2;
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  property p_result_latency;
    @(posedge core_clk) disable iff (!resetn)
      $rose(comp_raw_out) ##1 comp_raw_out |-> ##[0:1] compare_result;
  endproperty
  a_result_latency: assert property (p_result_latency)
    else $error("Result not synchronised in two cycles.");

  property p_flag_set;
    @(posedge core_clk) disable iff (!resetn)
      match |=> compare_event_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Flag not set by matching edge.");

  property p_flag_clear;
    @(posedge core_clk) disable iff (!resetn)
      vector_ack && !match |=> !compare_event_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Flag not cleared by vector acknowledge.");

  property p_irq_req;
    @(posedge core_clk) disable iff (!resetn)
      compare_irq_req == ($past(compare_event_flag)
        && $past(compare_irq_enable) && $past(global_irq_enable));
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("Interrupt request without all enables.");

  property p_reserved;
    @(posedge core_clk) disable iff (!resetn)
      edge_mode == 2'h1 |-> !match;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved mode produced an event.");

  property p_rise_mode;
    @(posedge core_clk) disable iff (!resetn)
      edge_mode == `CEC_MODE_RISE && $fell(compare_result) |-> !match;
  endproperty
  a_rise_mode: assert property (p_rise_mode)
    else $error("Falling edge matched rising mode.");

  property p_capture;
    @(posedge core_clk) disable iff (!resetn)
      !capture_route_enable |=> !capture_source;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Capture driven while route disabled.");

  property p_buffer_off;
    @(posedge core_clk) disable iff (!resetn)
      positive_pin_buffer_off |=> !positive_port_in;
  endproperty
  a_buffer_off: assert property (p_buffer_off)
    else $error("Port input not zero with buffer off.");

  property p_power_off;
    @(posedge core_clk) disable iff (!resetn)
      wr_ctrl |=> comparator_power_off == $past(avs_writedata[7]);
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("Power-off bit not written.");
endmodule

// *** comparator_event_control_tb.sv ***
// Self-checking bench for the comparator event control block.
`timescale 1ns/100ps
`include "cec_cfg.svh"
module comparator_event_control_tb;
  logic        core_clk, resetn, avs_read, avs_write, vector_ack;
  logic        glb, pos_dig, neg_dig, raw, pwr_off, ref_sel, pos_off;
  logic        neg_off, pos_in, neg_in, cap_en, cap_src, req, irq, wreq;
  logic        cap_ie, cap_irq;
  logic [3:0]  avs_address, avs_be;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0]  avs_response, r;
  logic [15:0] pos_mv, neg_mv;
  logic [7:0]  cap_cnt, q, c0;
  int          fails, n_tests;

  cec_top dut (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_be),
    .avs_readdata(avs_readdata), .avs_waitrequest(wreq),
    .avs_response(avs_response), .comp_raw_out(raw),
    .comparator_power_off(pwr_off), .reference_select(ref_sel),
    .positive_input_pin_digital(pos_dig),
    .negative_input_pin_digital(neg_dig),
    .positive_pin_buffer_off(pos_off), .negative_pin_buffer_off(neg_off),
    .positive_port_in(pos_in), .negative_port_in(neg_in),
    .capture_route_enable(cap_en), .capture_source(cap_src),
    .global_irq_enable(glb), .vector_ack(vector_ack),
    .compare_irq_req(req), .irq(irq));

  cec_cmp_model model (.core_clk(core_clk), .resetn(resetn),
    .pos_mv(pos_mv), .neg_mv(neg_mv), .power_off(pwr_off),
    .ref_sel(ref_sel), .capture_source(cap_src),
    .capture_irq_enable(cap_ie), .raw_out(raw),
    .capture_count(cap_cnt), .capture_irq(cap_irq));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  // One bus access, held until waitrequest is sampled low.
  task automatic acc(logic w, logic [3:0] a, logic [7:0] d);
    int i;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_be        <= 4'h1;
    avs_writedata <= {24'h000000, d};
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wreq !== 1'b0 && i < 50);
    if (i >= 50) begin
      fails++;
      summarize();
    end
    q = avs_readdata[7:0];
    r = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic cmp(logic hi);
    pos_mv <= hi ? 16'd900 : 16'd100;
    repeat (5) @(posedge core_clk);
  endtask

  initial begin
    resetn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; vector_ack = 1'b0;
    avs_address = 4'h0; avs_be = 4'h1; avs_writedata = 32'h0;
    glb = 1'b0; pos_dig = 1'b0; neg_dig = 1'b0; cap_ie = 1'b0;
    pos_mv = 16'd100; neg_mv = 16'd500;
    fails = 0; n_tests = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // ------------------------------------------------------------
    // Reset values and unmapped access.
    // ------------------------------------------------------------
    acc(1'b0, `CEC_OFF_CTRL, 8'h00);
    chk("ctrl", `CEC_CTRL_RESET, q);
    acc(1'b0, `CEC_OFF_PIN_DIGITAL_INPUT_DISABLE, 8'h00);
    chk("pin_digital_input_disable", `CEC_PIN_DIGITAL_INPUT_DISABLE_RESET, q);
    acc(1'b0, 4'h2, 8'h00);
    chk("resp", 8'h02, {6'h00, r});
    chk("unmapped", 8'h00, q);
    // ------------------------------------------------------------
    // Result, reference select and power off.
    // ------------------------------------------------------------
    cmp(1'b1);
    acc(1'b0, `CEC_OFF_CTRL, 8'h00);
    chk("result", 8'h20, q & 8'h20);
    neg_mv <= 16'd1000;
    cmp(1'b1);
    acc(1'b0, `CEC_OFF_CTRL, 8'h00);
    chk("result low", 8'h00, q & 8'h20);
    acc(1'b1, `CEC_OFF_CTRL, 8'h50);
    repeat (4) @(posedge core_clk);
    acc(1'b0, `CEC_OFF_CTRL, 8'h00);
    chk("bandgap", 8'h20, q & 8'h20);
    chk("ref sel", 8'h01, {7'h00, ref_sel});
    acc(1'b1, `CEC_OFF_CTRL, 8'hd0);
    repeat (4) @(posedge core_clk);
    acc(1'b0, `CEC_OFF_CTRL, 8'h00);
    chk("off result", 8'h00, q & 8'h20);
    chk("power off", 8'h01, {7'h00, pwr_off});
    acc(1'b1, `CEC_OFF_CTRL, 8'h10);
    neg_mv <= 16'd500;
    // ------------------------------------------------------------
    // Edge modes.
    // ------------------------------------------------------------
    for (int m = 0; m < 4; m++) begin
      cmp(1'b0);
      acc(1'b1, `CEC_OFF_CTRL, 8'h10 | 8'(m));
      cmp(1'b1);
      acc(1'b0, `CEC_OFF_CTRL, 8'h00);
      chk("rise", m % 3 == 0 ? 8'h10 : 8'h00, q & 8'h10);
      acc(1'b1, `CEC_OFF_CTRL, 8'h10 | 8'(m));
      cmp(1'b0);
      acc(1'b0, `CEC_OFF_CTRL, 8'h00);
      chk("fall", m % 2 == 0 ? 8'h10 : 8'h00, q & 8'h10);
    end
    // ------------------------------------------------------------
    // Interrupt request, vector and write-one clear.
    // ------------------------------------------------------------
    glb <= 1'b1;
    acc(1'b1, `CEC_OFF_CTRL, 8'h1b);
    cmp(1'b1);
    chk("req", 8'h01, {7'h00, req});
    glb <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("req no global", 8'h00, {7'h00, req});
    glb <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("req global", 8'h01, {7'h00, req});
    vector_ack <= 1'b1;
    @(posedge core_clk);
    vector_ack <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("req ack", 8'h00, {7'h00, req});
    cmp(1'b0);
    cmp(1'b1);
    acc(1'b1, `CEC_OFF_CTRL, 8'h03);
    repeat (2) @(posedge core_clk);
    chk("req disabled", 8'h00, {7'h00, req});
    acc(1'b0, `CEC_OFF_CTRL, 8'h00);
    chk("flag kept", 8'h10, q & 8'h10);
    acc(1'b1, `CEC_OFF_CTRL, 8'h13);
    acc(1'b0, `CEC_OFF_CTRL, 8'h00);
    chk("flag w1c", 8'h00, q & 8'h10);
    // ------------------------------------------------------------
    // Capture route.
    // ------------------------------------------------------------
    acc(1'b1, `CEC_OFF_CTRL, 8'h04);
    cmp(1'b0);
    c0 = cap_cnt;
    chk("cap irq off", 8'h00, {7'h00, cap_irq});
    cap_ie <= 1'b1;
    cmp(1'b1);
    chk("cap route", 8'h03, {6'h00, cap_en, cap_src});
    chk("cap count", c0 + 8'h01, cap_cnt);
    chk("cap irq", 8'h01, {7'h00, cap_irq});
    acc(1'b1, `CEC_OFF_CTRL, 8'h00);
    repeat (2) @(posedge core_clk);
    chk("cap off", 8'h00, {6'h00, cap_en, cap_src});
    // ------------------------------------------------------------
    // Digital input disable.
    // ------------------------------------------------------------
    pos_dig <= 1'b1;
    neg_dig <= 1'b1;
    acc(1'b1, `CEC_OFF_PIN_DIGITAL_INPUT_DISABLE, 8'h03);
    repeat (4) @(posedge core_clk);
    chk("pins off", 8'h0c, {4'h0, pos_off, neg_off, pos_in, neg_in});
    acc(1'b0, `CEC_OFF_PIN_DIGITAL_INPUT_DISABLE, 8'h00);
    chk("pin_digital_input_disable rd", 8'h03, q);
    acc(1'b1, `CEC_OFF_PIN_DIGITAL_INPUT_DISABLE, 8'h00);
    repeat (4) @(posedge core_clk);
    chk("pins on", 8'h03, {4'h0, pos_off, neg_off, pos_in, neg_in});
    // ------------------------------------------------------------
    // Status, mask and level interrupt.
    // ------------------------------------------------------------
    acc(1'b1, `CEC_OFF_MASK, 8'h01);
    acc(1'b1, `CEC_OFF_CTRL, 8'h13);
    cmp(1'b0);
    acc(1'b0, `CEC_OFF_STATUS, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq});
    cmp(1'b1);
    chk("irq", 8'h01, {7'h00, irq});
    acc(1'b0, `CEC_OFF_STATUS, 8'h00);
    chk("status", 8'h03, q);
    chk("irq clr", 8'h00, {7'h00, irq});
    acc(1'b1, `CEC_OFF_MASK, 8'h00);
    cmp(1'b0);
    cmp(1'b1);
    chk("irq mask", 8'h00, {7'h00, irq});
    acc(1'b0, `CEC_OFF_STATUS, 8'h00);
    chk("status both", 8'h07, q);
    summarize();
  end
endmodule
